// ---- hw/lbrd_stage.sv ----
/*
  Local buffer read stage: input half computes pixel addresses and feeds the
  read and write address queues, output half merges returned read words into
  the message stream ahead of the message that caused them.
  Assumes neighbours share i_mclk; every handoff is valid/ready.
*/
// Function
// R1 - register group messages load, never forwarded
// R2 - prerender pushes hold entry, queued enables cleared
// R3 - active step computes addresses; dest-only pushes dest
// R4 - source-only pushes source; none pushes nothing
// R5 - both enables: destination then source pushed
// R6 - every active step pushes dest write address
// R7 - active step queued with enables and type
// R8 - other messages queued with enables cleared
// R9 - 24-bit signed offset; dest equals source plus
// R10 - 24-bit window base used in address
// R11 - output waits room and read word
// R12 - dest-only default emits dest fragment data
// R13 - source-only default emits source fragment data
// R14 - stencil upload packs stencil, frame, owner
// R15 - depth upload carries zero-extended depth
// R16 - both reads: dest message then source message
// R17 - each read message pops one word
// R18 - original message forwarded after inserted data
// R19 - software sets upload mode, disables discards
// R20 - software rasterises destination, programs offset
// R21 - enables and type travel with message
// R22 - software drains reads before format change
// R23 - all handoffs stall, nothing dropped or duplicated
`timescale 1ns/10ps
module lbrd_stage (
  // clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  // incoming message stream
  input  wire logic        i_in_valid,
  output logic             o_in_ready,
  input  wire logic [8:0]  i_in_tag,
  input  wire logic [31:0] i_in_data,
  // read address queue towards the buffer interface
  output logic             o_ra_valid,
  input  wire logic        i_ra_ready,
  output logic [23:0]      o_ra_addr,
  output logic             o_ra_hold,
  // write address queue towards the buffer interface
  output logic             o_wa_valid,
  input  wire logic        i_wa_ready,
  output logic [23:0]      o_wa_addr,
  // returned read words
  input  wire logic        i_rd_valid,
  output logic             o_rd_ready,
  input  wire logic [51:0] i_rd_data,
  // outgoing message stream
  output logic             o_out_valid,
  input  wire logic        i_out_ready,
  output logic [8:0]       o_out_tag,
  output logic [51:0]      o_out_data
);

  // ------------------------------------------------------------------
  // read message builder
  // ------------------------------------------------------------------
  // picks tag and packing for one returned word; a two-read pair always
  // uses the plain fragment messages whatever upload type is set
  function automatic logic [60:0] read_msg(input logic both, input logic second,
                                           input logic dest_en, input logic [1:0] mtype,
                                           input logic [51:0] word);
    logic [8:0]  tag;
    logic [51:0] dat;
    tag = lbrd_pkg::TAG_DEST_DATA;
    dat = word;
    if (both) begin
      tag = second ? lbrd_pkg::TAG_SRC_DATA : lbrd_pkg::TAG_DEST_DATA; // R16
    end else if (mtype == lbrd_pkg::MSG_STENCIL) begin
      tag = lbrd_pkg::TAG_STENCIL_UP; // R14
      dat = {32'h00000000, word[lbrd_pkg::GID_LO +: 4],
             word[lbrd_pkg::FRAME_LO +: 8], word[lbrd_pkg::STEN_LO +: 8]};
    end else if (mtype == lbrd_pkg::MSG_DEPTH) begin
      tag = lbrd_pkg::TAG_DEPTH_UP; // R15
      dat = {20'h00000, word[lbrd_pkg::DEPTH_LO +: 32]};
    end else begin
      tag = dest_en ? lbrd_pkg::TAG_DEST_DATA : lbrd_pkg::TAG_SRC_DATA; // R12 R13
    end
    return {tag, dat};
  endfunction

  // ------------------------------------------------------------------
  // state and decode
  // ------------------------------------------------------------------
  lbrd_pkg::lbrd_state_t st_r;      // all registered state
  lbrd_pkg::lbrd_state_t st_nxt;    // its next value
  logic                  in_fire;   // input message taken
  logic                  is_reg;    // tag in the register group
  logic                  mq_full;   // message queue full
  logic                  mq_push;   // queue write this cycle
  logic                  mq_pop;    // queue read this cycle
  logic                  room;      // output register is free or next unit is ready
  logic                  rd_fire;   // read word consumed
  logic [44:0]           head;      // oldest queued message
  logic                  h_dest;    // head read_dest_enable
  logic                  h_src;     // head read_src_enable
  logic [1:0]            h_type;    // head data message type
  logic [60:0]           rmsg;      // built read message

  assign is_reg  = (i_in_tag == lbrd_pkg::TAG_READ_MODE) ||
                   (i_in_tag == lbrd_pkg::TAG_READ_FORMAT) ||
                   (i_in_tag == lbrd_pkg::TAG_SRC_OFFSET) ||
                   (i_in_tag == lbrd_pkg::TAG_WIN_BASE);
  assign mq_full = (st_r.mq_cnt == 4'(lbrd_pkg::MQ_DEPTH));
  assign head    = st_r.mq_mem[st_r.mq_rp];
  assign h_dest  = head[41];
  assign h_src   = head[42];
  assign h_type  = head[44:43];
  assign room    = !st_r.out_v || i_out_ready; // R23

  // ------------------------------------------------------------------
  // handshake outputs
  // ------------------------------------------------------------------
  // ready/valid are decoded from state so a stalled neighbour simply holds us
  assign o_in_ready  = (st_r.in_st == lbrd_pkg::IN_IDLE);
  assign in_fire     = i_in_valid && o_in_ready;
  assign o_ra_valid  = (st_r.in_st == lbrd_pkg::IN_RA_HOLD) ||
                       (st_r.in_st == lbrd_pkg::IN_RA_DEST) ||
                       (st_r.in_st == lbrd_pkg::IN_RA_SRC);
  assign o_ra_hold   = (st_r.in_st == lbrd_pkg::IN_RA_HOLD); // R2
  // address is don't-care on the hold entry; source is sent for it
  assign o_ra_addr   = (st_r.in_st == lbrd_pkg::IN_RA_DEST) ? st_r.dest_addr
                                                            : st_r.src_addr;
  assign o_wa_valid  = (st_r.in_st == lbrd_pkg::IN_WA);
  assign o_wa_addr   = st_r.dest_addr; // R6
  assign mq_push     = (st_r.in_st == lbrd_pkg::IN_MQ) && !mq_full;
  assign o_out_valid = st_r.out_v;
  assign o_out_tag   = st_r.out_tag;
  assign o_out_data  = st_r.out_data;

  // read word taken only when a read-data message is built this cycle
  assign o_rd_ready = room && st_r.mq_cnt != 4'h0 &&
                      ((st_r.out_st == lbrd_pkg::OS_FIRST && (h_dest || h_src)) ||
                       st_r.out_st == lbrd_pkg::OS_SECOND); // R11
  assign rd_fire    = o_rd_ready && i_rd_valid; // R17
  assign mq_pop     = room && st_r.mq_cnt != 4'h0 &&
                      (st_r.out_st == lbrd_pkg::OS_FWD ||
                       (st_r.out_st == lbrd_pkg::OS_FIRST && !h_dest && !h_src));
  assign rmsg = read_msg(h_dest && h_src, st_r.out_st == lbrd_pkg::OS_SECOND,
                         h_dest, h_type, i_rd_data);

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    // input half
    unique case (st_r.in_st)
      lbrd_pkg::IN_IDLE: begin
        if (in_fire && is_reg) begin
          // register messages end here; nothing is queued
          unique case (i_in_tag)
            lbrd_pkg::TAG_READ_MODE:   st_nxt.read_mode   = i_in_data[3:0]; // R1
            lbrd_pkg::TAG_READ_FORMAT: st_nxt.read_format = i_in_data;
            lbrd_pkg::TAG_SRC_OFFSET:  st_nxt.src_offset  = i_in_data[23:0]; // R9
            default:                   st_nxt.win_base    = i_in_data[23:0]; // R10
          endcase
        end else if (in_fire) begin
          st_nxt.msg_tag  = i_in_tag;
          st_nxt.msg_data = i_in_data;
          if (i_in_tag == lbrd_pkg::TAG_PRERENDER) begin
            st_nxt.in_st = lbrd_pkg::IN_RA_HOLD; // R2
          end else if (i_in_tag == lbrd_pkg::TAG_ACTIVE_STEP) begin
            // destination is rasterised; source sits one offset behind
            st_nxt.dest_addr = st_r.win_base + i_in_data[23:0]; // R3 R10
            st_nxt.src_addr  = st_r.win_base + i_in_data[23:0] - st_r.src_offset; // R9
            if (st_r.read_mode[lbrd_pkg::MODE_DEST_BIT]) begin
              st_nxt.in_st = lbrd_pkg::IN_RA_DEST; // R3 R5
            end else if (st_r.read_mode[lbrd_pkg::MODE_SRC_BIT]) begin
              st_nxt.in_st = lbrd_pkg::IN_RA_SRC; // R4
            end else begin
              st_nxt.in_st = lbrd_pkg::IN_WA; // R4
            end
          end else begin
            st_nxt.in_st = lbrd_pkg::IN_MQ; // R8
          end
        end
      end
      lbrd_pkg::IN_RA_HOLD: begin
        if (i_ra_ready) st_nxt.in_st = lbrd_pkg::IN_MQ;
      end
      lbrd_pkg::IN_RA_DEST: begin
        if (i_ra_ready) begin
          st_nxt.in_st = st_r.read_mode[lbrd_pkg::MODE_SRC_BIT] ? lbrd_pkg::IN_RA_SRC
                                                                : lbrd_pkg::IN_WA; // R5
        end
      end
      lbrd_pkg::IN_RA_SRC: begin
        if (i_ra_ready) st_nxt.in_st = lbrd_pkg::IN_WA;
      end
      lbrd_pkg::IN_WA: begin
        if (i_wa_ready) st_nxt.in_st = lbrd_pkg::IN_MQ; // R6
      end
      lbrd_pkg::IN_MQ: begin
        if (mq_push) begin
          // mode bits ride with the message so later mode writes cannot
          // change how its reads are merged
          if (st_r.msg_tag == lbrd_pkg::TAG_ACTIVE_STEP) begin
            st_nxt.mq_mem[st_r.mq_wp] = {st_r.read_mode, st_r.msg_tag,
                                         st_r.msg_data}; // R7 R21
          end else begin
            st_nxt.mq_mem[st_r.mq_wp] = {st_r.read_mode[3:2], 2'h0, st_r.msg_tag,
                                         st_r.msg_data}; // R2 R8
          end
          st_nxt.mq_wp = st_r.mq_wp + 3'h1;
          st_nxt.in_st = lbrd_pkg::IN_IDLE;
        end
      end
      default: st_nxt.in_st = lbrd_pkg::IN_IDLE;
    endcase

    // output half: message register drains when the next unit is ready
    if (i_out_ready) st_nxt.out_v = 1'b0;
    if (rd_fire) begin
      st_nxt.out_v    = 1'b1; // R11
      st_nxt.out_tag  = rmsg[60:52];
      st_nxt.out_data = rmsg[51:0];
      st_nxt.out_st   = (st_r.out_st == lbrd_pkg::OS_FIRST && h_dest && h_src) ?
                        lbrd_pkg::OS_SECOND : lbrd_pkg::OS_FWD; // R16
    end else if (mq_pop) begin
      st_nxt.out_v    = 1'b1; // R18
      st_nxt.out_tag  = head[40:32];
      st_nxt.out_data = {20'h00000, head[31:0]};
      st_nxt.out_st   = lbrd_pkg::OS_FIRST;
    end
    st_nxt.mq_rp  = st_r.mq_rp + {2'h0, mq_pop};
    st_nxt.mq_cnt = st_r.mq_cnt + {3'h0, mq_push} - {3'h0, mq_pop}; // R23
  end

  // ------------------------------------------------------------------
  // state register
  // ------------------------------------------------------------------
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      st_r            <= '0;
      st_r.in_st      <= lbrd_pkg::IN_IDLE;
      st_r.out_st     <= lbrd_pkg::OS_FIRST;
      st_r.read_mode  <= lbrd_pkg::RST_MODE;
      st_r.src_offset <= lbrd_pkg::RST_OFFSET;
      st_r.win_base   <= lbrd_pkg::RST_BASE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  // a register message must leave the queue write pointer where it was
  reg_no_fwd_a: assert property (in_fire && is_reg |=> st_r.in_st == lbrd_pkg::IN_IDLE // R1
    && !mq_push && st_r.mq_wp == $past(st_r.mq_wp))
    else $error("register message was queued");
  hold_push_a: assert property (in_fire && i_in_tag == lbrd_pkg::TAG_PRERENDER |=> // R2
    o_ra_valid && o_ra_hold) else $error("prerender did not raise hold entry");
  dest_calc_a: assert property (in_fire && i_in_tag == lbrd_pkg::TAG_ACTIVE_STEP |=> // R9
    st_r.dest_addr == st_r.src_addr + st_r.src_offset &&
    st_r.dest_addr == st_r.win_base + $past(i_in_data[23:0]))
    else $error("pixel address wrong");
  dest_then_src_a: assert property (o_ra_valid && i_ra_ready && // R5
    st_r.in_st == lbrd_pkg::IN_RA_DEST && st_r.read_mode[1:0] == 2'h3 |=>
    o_ra_valid && o_ra_addr == st_r.src_addr) else $error("source read missing");
  wa_before_mq_a: assert property (o_wa_valid && i_wa_ready |=> // R6
    st_r.in_st == lbrd_pkg::IN_MQ) else $error("write address order broken");
  rd_pop_once_a: assert property (rd_fire |-> !mq_pop ##1 st_r.out_v) // R17
    else $error("read word pop not paired with message");
  stencil_pack_a: assert property (st_r.out_v && st_r.out_tag == lbrd_pkg::TAG_STENCIL_UP // R14
    |-> st_r.out_data[51:20] == 32'h00000000) else $error("stencil packing wrong");
  depth_ext_a: assert property (rd_fire && !(h_dest && h_src) && // R15
    h_type == lbrd_pkg::MSG_DEPTH |=> st_r.out_tag == lbrd_pkg::TAG_DEPTH_UP &&
    st_r.out_data == {20'h00000, $past(i_rd_data[31:0])}) else $error("depth upload wrong");
  pair_order_a: assert property (rd_fire && st_r.out_st == lbrd_pkg::OS_FIRST && // R16
    h_dest && h_src |=> st_r.out_tag == lbrd_pkg::TAG_DEST_DATA &&
    st_r.out_st == lbrd_pkg::OS_SECOND) else $error("pair order wrong");
  fwd_after_a: assert property (mq_pop |=> st_r.out_v && // R18
    st_r.out_tag == $past(head[40:32])) else $error("queued message not forwarded");

endmodule

// ---- hw/lbrd_pkg.sv ----
/*
  Shared constants and types for the local buffer read stage: message tags,
  read mode field layout, queue depth and the packed state record.
  Assumes one 25 MHz clock domain shared with all neighbouring pipeline units.
*/
package lbrd_pkg;
  // ------------------------------------------------------------------
  // widths
  // ------------------------------------------------------------------
  localparam int TAG_W   = 9;   // message tag field
  localparam int DATA_W  = 32;  // input message data field
  localparam int ODATA_W = 52;  // widened output data field
  localparam int ADDR_W  = 24;  // local buffer pixel address
  localparam int MQ_DEPTH = 8;  // message queue slots
  localparam int MQ_AW    = 3;  // message queue pointer width
  localparam int MQ_ENT_W = 45; // {msg_type, src_en, dest_en, tag, data}

  // ------------------------------------------------------------------
  // message tags (input group, walk group, output group)
  // ------------------------------------------------------------------
  localparam logic [8:0] TAG_READ_MODE   = 9'h0D0; // local_read_mode_msg
  localparam logic [8:0] TAG_READ_FORMAT = 9'h0D1; // local_read_format_msg
  localparam logic [8:0] TAG_SRC_OFFSET  = 9'h0D2; // source_to_dest_offset
  localparam logic [8:0] TAG_WIN_BASE    = 9'h0D3; // window_base_address
  localparam logic [8:0] TAG_PRERENDER   = 9'h010; // prerender_msg
  localparam logic [8:0] TAG_ACTIVE_STEP = 9'h011; // active_walk_step_msg
  localparam logic [8:0] TAG_DEST_DATA   = 9'h0D8; // dest_fragment_data_msg
  localparam logic [8:0] TAG_SRC_DATA    = 9'h0D9; // source_fragment_data_msg
  localparam logic [8:0] TAG_STENCIL_UP  = 9'h0DA; // stencil_upload_msg
  localparam logic [8:0] TAG_DEPTH_UP    = 9'h0DB; // depth_upload_msg

  // ------------------------------------------------------------------
  // read mode register fields and data message types
  // ------------------------------------------------------------------
  localparam int MODE_DEST_BIT = 0;  // read_dest_enable
  localparam int MODE_SRC_BIT  = 1;  // read_src_enable
  localparam int MODE_TYPE_LO  = 2;  // data message type, 2 bits
  localparam logic [1:0] MSG_DEFAULT = 2'h0;
  localparam logic [1:0] MSG_STENCIL = 2'h1;
  localparam logic [1:0] MSG_DEPTH   = 2'h2;

  // internal read word layout: depth 31:0, stencil 39:32, frame 47:40, gid 51:48
  localparam int DEPTH_LO = 0;
  localparam int STEN_LO  = 32;
  localparam int FRAME_LO = 40;
  localparam int GID_LO   = 48;

  // reset values
  localparam logic [3:0]  RST_MODE   = 4'h0;
  localparam logic [23:0] RST_OFFSET = 24'h000000;
  localparam logic [23:0] RST_BASE   = 24'h000000;

  typedef enum logic [2:0] {IN_IDLE, IN_RA_HOLD, IN_RA_DEST, IN_RA_SRC, IN_WA, IN_MQ}
    lbrd_in_st_t;
  typedef enum logic [1:0] {OS_FIRST, OS_SECOND, OS_FWD} lbrd_out_st_t;

  typedef struct packed {
    lbrd_in_st_t                 in_st;
    logic [8:0]                  msg_tag;
    logic [31:0]                 msg_data;
    logic [23:0]                 dest_addr;
    logic [23:0]                 src_addr;
    logic [23:0]                 src_offset;
    logic [23:0]                 win_base;
    logic [3:0]                  read_mode;
    logic [31:0]                 read_format;
    logic [MQ_DEPTH-1:0][44:0]   mq_mem;
    logic [2:0]                  mq_wp;
    logic [2:0]                  mq_rp;
    logic [3:0]                  mq_cnt;
    lbrd_out_st_t                out_st;
    logic                        out_v;
    logic [8:0]                  out_tag;
    logic [51:0]                 out_data;
  } lbrd_state_t;
endpackage

// ---- verif/lbrd_far_model.sv ----
/*
  Far side of the local buffer read stage: a behavioural buffer interface that
  takes read and write addresses and returns one read word per real read.
  Assumes the stage shares i_mclk and that all handshakes are valid/ready.
*/
`timescale 1ns/10ps
module lbrd_far_model (
  // clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  // pacing: high makes every ready and every answer slow
  input  wire logic        i_slow,
  // read address queue
  input  wire logic        i_ra_valid,
  output logic             o_ra_ready,
  input  wire logic [23:0] i_ra_addr,
  input  wire logic        i_ra_hold,
  // write address queue
  input  wire logic        i_wa_valid,
  output logic             o_wa_ready,
  input  wire logic [23:0] i_wa_addr,
  // returned read words
  output logic             o_rd_valid,
  input  wire logic        i_rd_ready,
  output logic [51:0]      o_rd_data,
  // observation for the bench
  output logic [15:0]      o_ra_cnt,
  output logic [15:0]      o_wa_cnt,
  output logic [15:0]      o_hold_cnt,
  output logic [23:0]      o_wa_last
);
  logic [51:0] words[$];  // reads waiting to be returned
  logic        ph;        // slow pacing phase

  // ----------------------------------------------------------------
  // room in both address queues, alternating when slow
  // ----------------------------------------------------------------
  assign o_ra_ready = !i_slow || ph;
  assign o_wa_ready = !i_slow || !ph;

  // word layout: owner id, frame, stencil from the address, depth is the address
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      words.delete();
      ph         <= 1'b0;
      o_rd_valid <= 1'b0;
      o_rd_data  <= 52'h0;
      o_ra_cnt   <= 16'h0;
      o_wa_cnt   <= 16'h0;
      o_hold_cnt <= 16'h0;
      o_wa_last  <= 24'h0;
    end else begin
      ph <= !ph;
      if (i_ra_valid && o_ra_ready) begin
        // a hold entry only pauses reads, so no word comes back
        if (i_ra_hold) o_hold_cnt <= o_hold_cnt + 16'h1;
        else begin
          words.push_back({i_ra_addr[3:0], i_ra_addr[11:4], i_ra_addr[19:12], 8'h00, i_ra_addr});
          o_ra_cnt <= o_ra_cnt + 16'h1;
        end
      end
      if (i_wa_valid && o_wa_ready) begin
        o_wa_cnt  <= o_wa_cnt + 16'h1;
        o_wa_last <= i_wa_addr;
      end
      // a word stands until taken, then the data lines no longer hold it
      if (o_rd_valid && i_rd_ready) begin
        o_rd_valid <= 1'b0;
        o_rd_data  <= ~o_rd_data;
      end else if (!o_rd_valid && words.size() > 0 && (!i_slow || ph)) begin
        o_rd_valid <= 1'b1;
        o_rd_data  <= words.pop_front();
      end
    end
  end
endmodule

// ---- verif/tb.sv ----
/*
  Testbench for the local buffer read stage: message sequences with expected
  output streams, address counts and write addresses.
  Assumes the far model above stands on the buffer interface side.
*/
`timescale 1ns/10ps
module tb;
  logic i_mclk = 1'b0, i_rst = 1'b1, i_slow = 1'b0, out_hold = 1'b0;
  logic i_in_valid = 1'b0, i_out_ready = 1'b0, o_in_ready, o_out_valid;
  logic [8:0] i_in_tag = 9'h000, o_out_tag;
  logic [31:0] i_in_data = 32'h0;
  logic o_ra_valid, i_ra_ready, o_ra_hold, o_wa_valid, i_wa_ready, i_rd_valid, o_rd_ready;
  logic [23:0] o_ra_addr, o_wa_addr, o_wa_last, base = 24'h0, off = 24'h0, exp_wa = 24'h0;
  logic [51:0] i_rd_data, o_out_data;
  logic [15:0] o_ra_cnt, o_wa_cnt, o_hold_cnt;
  logic [60:0] exp_q[$], e_m;  // expected {tag, data} stream
  logic [3:0]  m = 4'h0;       // mode as the bench believes it
  logic [3:0]  modes[10] = '{4'h1, 4'h2, 4'h3, 4'h0, 4'h5, 4'h9, 4'h6, 4'hA, 4'h7, 4'hD};
  int n_fail = 0, samples_checked = 0, n_ra = 0, n_wa = 0, cyc = 0, i;

  always #20 i_mclk = ~i_mclk;
  lbrd_stage i_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_in_valid(i_in_valid),
    .o_in_ready(o_in_ready), .i_in_tag(i_in_tag), .i_in_data(i_in_data),
    .o_ra_valid(o_ra_valid), .i_ra_ready(i_ra_ready), .o_ra_addr(o_ra_addr),
    .o_ra_hold(o_ra_hold), .o_wa_valid(o_wa_valid), .i_wa_ready(i_wa_ready),
    .o_wa_addr(o_wa_addr), .i_rd_valid(i_rd_valid), .o_rd_ready(o_rd_ready),
    .i_rd_data(i_rd_data), .o_out_valid(o_out_valid), .i_out_ready(i_out_ready),
    .o_out_tag(o_out_tag), .o_out_data(o_out_data));
  lbrd_far_model i_far (.i_mclk(i_mclk), .i_rst(i_rst), .i_slow(i_slow),
    .i_ra_valid(o_ra_valid), .o_ra_ready(i_ra_ready), .i_ra_addr(o_ra_addr),
    .i_ra_hold(o_ra_hold), .i_wa_valid(o_wa_valid), .o_wa_ready(i_wa_ready),
    .i_wa_addr(o_wa_addr), .o_rd_valid(i_rd_valid), .i_rd_ready(o_rd_ready),
    .o_rd_data(i_rd_data), .o_ra_cnt(o_ra_cnt), .o_wa_cnt(o_wa_cnt),
    .o_hold_cnt(o_hold_cnt), .o_wa_last(o_wa_last));

  // next unit: stalls on request, otherwise takes every other cycle when slow
  always @(negedge i_mclk) begin
    cyc++;
    i_out_ready <= !out_hold && (!i_slow || cyc[0]);
  end

  task automatic chk(input string nm, input logic [51:0] e, input logic [51:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // every message taken by the next unit must be the next expected one
  always @(posedge i_mclk) begin
    if (o_out_valid === 1'b1 && i_out_ready === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_fail++;
        $display("BAD out_extra expected none seen %h", o_out_tag);
      end else begin
        e_m = exp_q.pop_front();
        chk("out_tag", {43'h0, e_m[60:52]}, {43'h0, o_out_tag});
        chk("out_data", e_m[51:0], o_out_data);
      end
    end
  end

  function automatic logic [51:0] wd(input logic [23:0] a);
    return {a[3:0], a[11:4], a[19:12], 8'h00, a};
  endfunction

  // one single read, wrapped as the message type in force says
  task automatic push_rd(input logic de, input logic [23:0] a);
    logic [51:0] w;
    w = wd(a);
    n_ra++;
    if (m[3:2] == lbrd_pkg::MSG_STENCIL)
      exp_q.push_back({lbrd_pkg::TAG_STENCIL_UP, 32'h0, w[51:48], w[47:40], w[39:32]});
    else if (m[3:2] == lbrd_pkg::MSG_DEPTH)
      exp_q.push_back({lbrd_pkg::TAG_DEPTH_UP, 20'h0, w[31:0]});
    else exp_q.push_back({de ? lbrd_pkg::TAG_DEST_DATA : lbrd_pkg::TAG_SRC_DATA, w});
  endtask

  // present one message, hold it until taken; valid stays up for the next call
  task automatic send(input logic [8:0] t, input logic [31:0] d);
    logic [23:0] da;
    logic [23:0] sa;
    int k;
    da = base + d[23:0];
    sa = da - off;
    case (t)
      lbrd_pkg::TAG_READ_MODE:   m = d[3:0];
      lbrd_pkg::TAG_SRC_OFFSET:  off = d[23:0];
      lbrd_pkg::TAG_WIN_BASE:    base = d[23:0];
      lbrd_pkg::TAG_READ_FORMAT: k = 0;
      lbrd_pkg::TAG_ACTIVE_STEP: begin
        if (m[0] && m[1]) begin
          exp_q.push_back({lbrd_pkg::TAG_DEST_DATA, wd(da)});
          exp_q.push_back({lbrd_pkg::TAG_SRC_DATA, wd(sa)});
          n_ra += 2;
        end else if (m[0]) push_rd(1'b1, da);
        else if (m[1]) push_rd(1'b0, sa);
        n_wa++;
        exp_wa = da;
        exp_q.push_back({t, 20'h0, d});
      end
      default: exp_q.push_back({t, 20'h0, d});
    endcase
    i_in_valid = 1'b1;
    i_in_tag   = t;
    i_in_data  = d;
    for (k = 0; k < 200; k++) begin
      @(posedge i_mclk);
      if (o_in_ready === 1'b1) break;
      @(negedge i_mclk);
    end
    if (k == 200) begin
      n_fail++;
      $display("BAD in_ready expected 1 seen %b", o_in_ready);
      final_report();
    end
    @(negedge i_mclk);
  endtask

  // let the stream run dry, then compare address traffic
  task automatic drain(input string nm);
    int k;
    i_in_valid = 1'b0;
    for (k = 0; k < 3000 && exp_q.size() > 0; k++) @(negedge i_mclk);
    if (exp_q.size() > 0) begin
      n_fail++;
      $display("BAD drain expected 0 seen %0d", exp_q.size());
      final_report();
    end
    repeat (4) @(negedge i_mclk);
    chk("ra_count", 52'(n_ra), {36'h0, o_ra_cnt});
    chk("wa_count", 52'(n_wa), {36'h0, o_wa_cnt});
    chk("wa_addr", {28'h0, exp_wa}, {28'h0, o_wa_last});
    $display("test %s done", nm);
  endtask

  initial begin
    repeat (2) @(negedge i_mclk);
    i_rst = 1'b0;
    // every read mode and message type, positive offset
    send(lbrd_pkg::TAG_WIN_BASE, 32'h0000_0100);
    send(lbrd_pkg::TAG_SRC_OFFSET, 32'h0000_0010);
    for (i = 0; i < 10; i++) begin
      send(lbrd_pkg::TAG_READ_MODE, {28'h0, modes[i]});
      send(lbrd_pkg::TAG_ACTIVE_STEP, 32'(3 * i + 1));
    end
    drain("modes");
    // prerender and an unknown message with reads enabled
    send(lbrd_pkg::TAG_READ_MODE, 32'h0000_0001);
    send(lbrd_pkg::TAG_PRERENDER, 32'h0000_005A);
    send(9'h055, 32'hCAFE_0001);
    drain("prerender");
    chk("hold_count", 52'h1, {36'h0, o_hold_cnt});
    // mode changes while earlier steps wait; negative offset
    i_slow = 1'b1;
    out_hold = 1'b1;
    send(lbrd_pkg::TAG_SRC_OFFSET, 32'h00FF_FFF0);
    send(lbrd_pkg::TAG_READ_MODE, 32'h0000_0001);
    send(lbrd_pkg::TAG_ACTIVE_STEP, 32'h0000_0007);
    send(lbrd_pkg::TAG_READ_MODE, 32'h0000_0002);
    send(lbrd_pkg::TAG_ACTIVE_STEP, 32'h0000_0008);
    send(lbrd_pkg::TAG_READ_MODE, 32'h0000_0009);
    send(lbrd_pkg::TAG_ACTIVE_STEP, 32'h0000_0009);
    out_hold = 1'b0;
    drain("stall");
    // format change only after all reads are done, then a burst
    send(lbrd_pkg::TAG_READ_FORMAT, 32'h0000_0000);
    for (i = 0; i < 12; i++) send(9'h060 + 9'(i), 32'(i));
    send(lbrd_pkg::TAG_ACTIVE_STEP, 32'h0000_0020);
    drain("burst");
    final_report();
  end
endmodule
